// ### dmcp_map.svh
// constants of the dual-mode control port: addresses, field positions,
// reset values and small counts.
// assumes nothing; included by dmcp_ctrl_port.sv, not by dmcp_pkg.sv.
`ifndef DMCP_MAP_SVH
`define DMCP_MAP_SVH

// fixed spi chip address, first seven bits of a frame
`define DMCP_SPI_CHIP_ADDR 7'h4f
// fixed upper five bits of the i2c slave address
`define DMCP_I2C_PREFIX 5'h13
// pointer byte layout: auto-increment flag on top
`define DMCP_PTR_INC_BIT 7
// reset value of every configuration register
`define DMCP_REG_RST 8'h00
// reset value of the pointer
`define DMCP_PTR_RST 8'h00
// ref_clk cycles spent catching the straps after reset release
`define DMCP_STRAP_CYC 2'h3
// bits in a byte, as seen by the bit counters
`define DMCP_LAST_BIT 3'h7
`define DMCP_BYTE_BITS 4'h8

`endif

// ### dmcp_pkg.sv
// types of the dual-mode control port.
// assumes nothing; does not include dmcp_map.svh.
package dmcp_pkg;

    // spi frame phase, link clock domain
    typedef enum logic [4:0] {
        DMCP_P_ADDR = 5'h01,
        DMCP_P_PTR = 5'h02,
        DMCP_P_DATA = 5'h04,
        DMCP_P_READ = 5'h08,
        DMCP_P_SKIP = 5'h10
    } dmcp_phase_e;

    // i2c slave state, ref_clk domain
    typedef enum logic [4:0] {
        DMCP_I_IDLE = 5'h01,
        DMCP_I_RECV = 5'h02,
        DMCP_I_ACK = 5'h04,
        DMCP_I_SEND = 5'h08,
        DMCP_I_MACK = 5'h10
    } dmcp_istate_e;

    // kind of byte handed from the spi side to the register side
    typedef enum logic [1:0] {
        DMCP_EV_PTR = 2'h0,
        DMCP_EV_WR = 2'h1,
        DMCP_EV_RD = 2'h2
    } dmcp_ev_e;

endpackage

// ### dmcp_ctrl_port.sv
// dual-mode (spi or i2c) slave control port with its configuration registers.
// assumes the host keeps the pins static between accesses and that
// select_or_addr0_pin is idle high in spi use or strapped in i2c use.
`timescale 1ns/1ps
`include "dmcp_map.svh"

module dmcp_ctrl_port
    import dmcp_pkg::*;
#(
    parameter int NUM_REGS = 64
) (
    // system clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // link pins
    input wire logic control_bit_clock,
    input wire logic select_or_addr0_pin,
    input wire logic addr_strap_bit1,
    input wire logic control_serial_in,
    output logic control_serial_out,
    output logic control_serial_out_oe,
    // i2c data pin, open drain
    input wire logic i2c_data_in,
    output logic i2c_data_out,
    output logic i2c_data_oe,
    // towards the rest of the device
    output logic [NUM_REGS*8-1:0] cfg_regs,
    output logic ctrl_mode_spi,
    output logic [6:0] i2c_slave_addr
);

    localparam int AW = $clog2(NUM_REGS);

    // register side state, ref_clk domain
    typedef struct packed {
        logic cs_s1, cs_s2, cs_s3;        // select pin sync and history
        logic scl_s1, scl_s2, scl_s3;     // i2c clock sync and history
        logic sda_s1, sda_s2, sda_s3;     // i2c data sync and history
        logic a1_s1, a1_s2;               // strap bit1 sync
        logic ev_s1, ev_s2, ev_s3;        // spi byte toggle sync
        logic [1:0] strap_cnt;            // strap capture window
        logic addr_strap_bit0;            // caught strap bits
        logic addr_strap_bit1;
        logic mode_spi;                   // sticky spi selection
        logic [7:0] ptr;                  // pointer, flag on top
        logic [NUM_REGS-1:0][7:0] regs;   // configuration registers
        dmcp_istate_e ist;                // i2c slave state
        logic [3:0] bits;                 // i2c bit counter
        logic [7:0] shift;                // i2c receive shifter
        logic [7:0] tx;                   // i2c transmit shifter
        logic is_addr;                    // next byte is the address byte
        logic is_read;                    // current transfer direction
        logic got_ptr;                    // pointer byte already taken
        logic sda_oe;                     // pulling the data line low
    } dmcp_ref_s;

    // spi side state, link clock domain
    typedef struct packed {
        logic m_s1, m_s2;                 // mode sync into the link domain
        dmcp_phase_e phase;
        logic [2:0] bits;
        logic [6:0] shift;
        logic [7:0] tx;
    } dmcp_spi_s;

    // byte hand-over to the register side, link clock domain
    typedef struct packed {
        logic ev_tgl;                     // flips once per byte handed over
        dmcp_ev_e ev_kind;
        logic [7:0] ev_byte;
    } dmcp_hand_s;

    dmcp_ref_s r_ff, nxt_r;
    dmcp_spi_s s_ff, nxt_s;
    dmcp_hand_s h_ff, nxt_h;            // kept apart: other reset than the frame
    logic sdo_ff, sdo_oe_ff;            // falling-edge output flops
    logic spi_arst_b;                   // frame reset: chip reset or deselect
    logic [7:0] spi_rd_byte;            // register under the pointer
    logic [7:0] sbyte;                  // spi byte completed this edge
    logic [AW-1:0] ptr_idx;
    logic ev_seen, scl_rise, scl_fall, i2c_start, i2c_stop, addr_hit;

    // deselect ends a frame even though the host clock has stopped
    assign spi_arst_b = rst_b & ~select_or_addr0_pin;
    assign ptr_idx = r_ff.ptr[AW-1:0];
    // pointer only moves after a handed-over byte, several link bits before
    // the spi side samples this again, so it is quasi-static there
    assign spi_rd_byte = r_ff.regs[ptr_idx];

    assign ev_seen = r_ff.ev_s2 ^ r_ff.ev_s3;
    assign scl_rise = r_ff.scl_s2 & ~r_ff.scl_s3;
    assign scl_fall = ~r_ff.scl_s2 & r_ff.scl_s3;
    assign i2c_start = r_ff.scl_s2 & r_ff.scl_s3 & r_ff.sda_s3 & ~r_ff.sda_s2;
    assign i2c_stop = r_ff.scl_s2 & r_ff.scl_s3 & ~r_ff.sda_s3 & r_ff.sda_s2;
    // slave address from fixed prefix and caught straps
    assign addr_hit = (r_ff.shift[7:1] ==
        {`DMCP_I2C_PREFIX, r_ff.addr_strap_bit1, r_ff.addr_strap_bit0});

    // register side next state
    always_comb begin
        nxt_r = r_ff;
        // two flops before any pin is looked at
        nxt_r.cs_s1 = select_or_addr0_pin;
        nxt_r.cs_s2 = r_ff.cs_s1;
        nxt_r.cs_s3 = r_ff.cs_s2;
        nxt_r.scl_s1 = control_bit_clock;
        nxt_r.scl_s2 = r_ff.scl_s1;
        nxt_r.scl_s3 = r_ff.scl_s2;
        nxt_r.sda_s1 = i2c_data_in;
        nxt_r.sda_s2 = r_ff.sda_s1;
        nxt_r.sda_s3 = r_ff.sda_s2;
        nxt_r.a1_s1 = addr_strap_bit1;
        nxt_r.a1_s2 = r_ff.a1_s1;
        nxt_r.ev_s1 = h_ff.ev_tgl;
        nxt_r.ev_s2 = r_ff.ev_s1;
        nxt_r.ev_s3 = r_ff.ev_s2;
        // straps caught right after release, once the syncs hold pin levels
        if (r_ff.strap_cnt != `DMCP_STRAP_CYC) begin
            nxt_r.strap_cnt = r_ff.strap_cnt + 2'h1;
            nxt_r.addr_strap_bit0 = r_ff.cs_s2;
            nxt_r.addr_strap_bit1 = r_ff.a1_s2;
        end
        // any falling select edge after release switches to spi for good
        if (r_ff.cs_s3 && !r_ff.cs_s2) begin
            nxt_r.mode_spi = 1'b1;
        end
        if (r_ff.mode_spi) begin
            // spi bytes arrive already framed from the link domain
            nxt_r.ist = DMCP_I_IDLE;
            nxt_r.sda_oe = 1'b0;
            if (ev_seen) begin
                case (h_ff.ev_kind)
                    DMCP_EV_PTR: nxt_r.ptr = h_ff.ev_byte;
                    DMCP_EV_WR: begin
                        nxt_r.regs[ptr_idx] = h_ff.ev_byte;
                        if (r_ff.ptr[`DMCP_PTR_INC_BIT]) begin
                            nxt_r.ptr[6:0] = r_ff.ptr[6:0] + 7'h01;
                        end
                    end
                    default: begin
                        if (r_ff.ptr[`DMCP_PTR_INC_BIT]) begin
                            nxt_r.ptr[6:0] = r_ff.ptr[6:0] + 7'h01;
                        end
                    end
                endcase
            end
        end else if (i2c_start) begin
            // repeated start allowed from any state
            nxt_r.ist = DMCP_I_RECV;
            nxt_r.bits = 4'h0;
            nxt_r.is_addr = 1'b1;
            nxt_r.sda_oe = 1'b0;
        end else if (i2c_stop) begin
            nxt_r.ist = DMCP_I_IDLE;
            nxt_r.sda_oe = 1'b0;
        end else begin
            case (r_ff.ist)
                DMCP_I_RECV: begin
                    if (scl_rise) begin
                        nxt_r.shift = {r_ff.shift[6:0], r_ff.sda_s2};
                        nxt_r.bits = r_ff.bits + 4'h1;
                    end else if (scl_fall && r_ff.bits == `DMCP_BYTE_BITS) begin
                        nxt_r.is_addr = 1'b0;
                        nxt_r.ist = DMCP_I_ACK;
                        nxt_r.sda_oe = 1'b1;
                        if (r_ff.is_addr) begin
                            nxt_r.is_read = r_ff.shift[0];
                            nxt_r.got_ptr = 1'b0;
                            if (!addr_hit) begin
                                // not us: stay off the line until next start
                                nxt_r.ist = DMCP_I_IDLE;
                                nxt_r.sda_oe = 1'b0;
                            end
                        end else if (!r_ff.got_ptr) begin
                            nxt_r.ptr = r_ff.shift;
                            nxt_r.got_ptr = 1'b1;
                        end else begin
                            nxt_r.regs[ptr_idx] = r_ff.shift;
                            if (r_ff.ptr[`DMCP_PTR_INC_BIT]) begin
                                nxt_r.ptr[6:0] = r_ff.ptr[6:0] + 7'h01;
                            end
                        end
                    end
                end
                DMCP_I_ACK: begin
                    // ack slot, or master ack before the next byte out
                    if (scl_fall) begin
                        nxt_r.bits = 4'h0;
                        nxt_r.sda_oe = 1'b0;
                        nxt_r.ist = DMCP_I_RECV;
                        if (r_ff.is_read) begin
                            // pointer was set by an earlier write transfer
                            nxt_r.tx = spi_rd_byte;
                            nxt_r.sda_oe = ~spi_rd_byte[7];
                            nxt_r.bits = 4'h1;
                            nxt_r.ist = DMCP_I_SEND;
                            if (r_ff.ptr[`DMCP_PTR_INC_BIT]) begin
                                nxt_r.ptr[6:0] = r_ff.ptr[6:0] + 7'h01;
                            end
                        end
                    end
                end
                DMCP_I_SEND: begin
                    if (scl_fall) begin
                        if (r_ff.bits == `DMCP_BYTE_BITS) begin
                            nxt_r.sda_oe = 1'b0;
                            nxt_r.ist = DMCP_I_MACK;
                        end else begin
                            nxt_r.sda_oe = ~r_ff.tx[6];
                            nxt_r.tx = {r_ff.tx[6:0], 1'b0};
                            nxt_r.bits = r_ff.bits + 4'h1;
                        end
                    end
                end
                DMCP_I_MACK: begin
                    // host ack keeps the read going, nack ends it
                    if (scl_rise) begin
                        nxt_r.ist = r_ff.sda_s2 ? DMCP_I_IDLE : DMCP_I_ACK;
                    end
                end
                default: nxt_r.sda_oe = 1'b0;
            endcase
        end
    end

    // register side flops, cleared by the chip reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            nxt_r_rst: begin
                r_ff <= '0;
                r_ff.ist <= DMCP_I_IDLE;
                r_ff.ptr <= `DMCP_PTR_RST;
                r_ff.regs <= {NUM_REGS{`DMCP_REG_RST}};
            end
        end else begin
            r_ff <= nxt_r;
        end
    end

    // spi side next state, on rising link clock edges
    always_comb begin
        nxt_s = s_ff;
        nxt_h = h_ff;
        sbyte = {s_ff.shift, control_serial_in};
        nxt_s.m_s1 = r_ff.mode_spi;
        nxt_s.m_s2 = s_ff.m_s1;
        nxt_s.shift = sbyte[6:0];
        nxt_s.bits = s_ff.bits + 3'h1;
        if (s_ff.phase == DMCP_P_READ) begin
            nxt_s.tx = {s_ff.tx[6:0], 1'b0};
        end
        if (s_ff.bits == `DMCP_LAST_BIT) begin
            case (s_ff.phase)
                DMCP_P_ADDR: begin
                    if (sbyte[7:1] != `DMCP_SPI_CHIP_ADDR) begin
                        nxt_s.phase = DMCP_P_SKIP;
                    end else if (sbyte[0]) begin
                        // pointer was set by an earlier partial write
                        nxt_s.phase = DMCP_P_READ;
                        nxt_s.tx = spi_rd_byte;
                        nxt_h.ev_kind = DMCP_EV_RD;
                        nxt_h.ev_tgl = ~h_ff.ev_tgl;
                    end else begin
                        nxt_s.phase = DMCP_P_PTR;
                    end
                end
                DMCP_P_PTR: begin
                    nxt_s.phase = DMCP_P_DATA;
                    nxt_h.ev_kind = DMCP_EV_PTR;
                    nxt_h.ev_byte = sbyte;
                    nxt_h.ev_tgl = ~h_ff.ev_tgl;
                end
                DMCP_P_DATA: begin
                    nxt_h.ev_kind = DMCP_EV_WR;
                    nxt_h.ev_byte = sbyte;
                    nxt_h.ev_tgl = ~h_ff.ev_tgl;
                end
                DMCP_P_READ: begin
                    // register under the pointer, advanced since the last load only with increment on
                    nxt_s.tx = spi_rd_byte;
                    nxt_h.ev_kind = DMCP_EV_RD;
                    nxt_h.ev_tgl = ~h_ff.ev_tgl;
                end
                default: nxt_s.phase = DMCP_P_SKIP;
            endcase
        end
    end

    // spi frame flops, cleared by chip reset or deselect
    always_ff @(posedge control_bit_clock or negedge spi_arst_b) begin
        if (!spi_arst_b) begin
            s_ff <= '{default: '0, phase: DMCP_P_ADDR};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // byte hand-over holds across deselect, only chip reset clears it,
    // so the toggle never flips back and no byte is counted twice
    always_ff @(posedge control_bit_clock or negedge rst_b) begin
        if (!rst_b) begin
            h_ff <= '{ev_tgl: 1'b0, ev_kind: DMCP_EV_PTR, ev_byte: 8'h00};
        end else begin
            h_ff <= nxt_h;
        end
    end

    // serial output changes on falling edges, cleared at once by deselect or chip reset
    always_ff @(negedge control_bit_clock or negedge spi_arst_b) begin
        if (!spi_arst_b) begin
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else begin
            sdo_ff <= s_ff.tx[7];
            sdo_oe_ff <= (s_ff.phase == DMCP_P_READ) && s_ff.m_s2;
        end
    end

    // outputs
    assign control_serial_out = sdo_ff;
    assign control_serial_out_oe = sdo_oe_ff;
    assign i2c_data_out = 1'b0;
    assign i2c_data_oe = r_ff.sda_oe;
    assign cfg_regs = r_ff.regs;
    assign ctrl_mode_spi = r_ff.mode_spi;
    assign i2c_slave_addr = {`DMCP_I2C_PREFIX, r_ff.addr_strap_bit1, r_ff.addr_strap_bit0};

    // checks in the register clock domain
    default clocking dmcp_cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    logic spi_ev;
    assign spi_ev = ev_seen && r_ff.mode_spi;

    a_spi_mode_entry: assert property (r_ff.cs_s3 && !r_ff.cs_s2 |=> r_ff.mode_spi)
        else $error("spi mode not entered after select fell");
    a_spi_ptr_load: assert property (
        spi_ev && h_ff.ev_kind == DMCP_EV_PTR |=> r_ff.ptr == $past(h_ff.ev_byte))
        else $error("spi pointer byte not loaded");
    a_spi_reg_write: assert property (
        spi_ev && h_ff.ev_kind == DMCP_EV_WR
        |=> r_ff.regs[$past(ptr_idx)] == $past(h_ff.ev_byte))
        else $error("spi data byte not stored");
    a_ptr_hold_clear: assert property (
        spi_ev && h_ff.ev_kind != DMCP_EV_PTR && !r_ff.ptr[7] |=> $stable(r_ff.ptr))
        else $error("pointer moved with auto-increment off");
    a_ptr_inc_set: assert property (
        spi_ev && h_ff.ev_kind != DMCP_EV_PTR && r_ff.ptr[7]
        |=> r_ff.ptr[6:0] == 7'($past(r_ff.ptr[6:0]) + 7'h01))
        else $error("pointer did not advance with auto-increment on");
    a_i2c_addr_ack: assert property (
        !r_ff.mode_spi && !i2c_start && !i2c_stop
        && r_ff.ist == DMCP_I_RECV && scl_fall && r_ff.bits == 4'h8 && r_ff.is_addr
        |=> (r_ff.sda_oe == $past(addr_hit)) [*2])
        else $error("i2c address ack wrong");
    a_i2c_ptr_load: assert property (
        !r_ff.mode_spi && !i2c_start && !i2c_stop
        && r_ff.ist == DMCP_I_RECV && scl_fall && r_ff.bits == 4'h8
        && !r_ff.is_addr && !r_ff.got_ptr |=> r_ff.ptr == $past(r_ff.shift))
        else $error("i2c pointer byte not loaded");
    a_i2c_read_data: assert property (
        !r_ff.mode_spi && !i2c_start && !i2c_stop
        && r_ff.ist == DMCP_I_ACK && r_ff.is_read && scl_fall
        |=> r_ff.tx == $past(spi_rd_byte) && r_ff.sda_oe == !$past(spi_rd_byte[7]))
        else $error("i2c read did not load pointed register");

    // checks in the link clock domain
    a_spi_write_hiz: assert property (
        @(posedge control_bit_clock) disable iff (!spi_arst_b)
        s_ff.phase inside {DMCP_P_ADDR, DMCP_P_PTR, DMCP_P_DATA} |-> !sdo_oe_ff)
        else $error("serial output driven during write");

    c_spi_write: cover property (spi_ev && h_ff.ev_kind == DMCP_EV_WR);
    c_spi_read: cover property (spi_ev && h_ff.ev_kind == DMCP_EV_RD);
    c_i2c_write: cover property (r_ff.ist == DMCP_I_RECV && r_ff.got_ptr && scl_fall
        && r_ff.bits == 4'h8);
    c_i2c_read: cover property (r_ff.ist == DMCP_I_MACK ##1 r_ff.ist == DMCP_I_ACK);

endmodule

// ### dmcp_host.sv
// host model: spi master and i2c master sharing the control pins.
// assumes the bench pulls the i2c data wire up and ties these pins to the port.
`timescale 1ns/1ps
module dmcp_host (
    // pins towards the port
    output logic bit_clk,
    output logic sel_n,
    output logic mosi,
    output logic sda_low,
    // pins from the port
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic sda
);
    logic oe_seen; // spi output drive seen during a frame
    // pins static, i2c idle levels at time zero
    initial begin
        bit_clk = 1'b1;
        sel_n = 1'b1;
        mosi = 1'b0;
        sda_low = 1'b0;
        oe_seen = 1'b0;
    end
    // spi clock idles low, only moved before a select falls
    task automatic spi_idle();
        bit_clk = 1'b0;
        oe_seen = 1'b0;
    endtask
    // select low opens a frame, high closes it
    task automatic spi_sel(input logic low);
        sel_n = !low;
        #24;
    endtask
    // one byte msb first: data set after fall, both sides sampled on rise
    task automatic spi_byte(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            mosi = b[i];
            #24 bit_clk = 1'b1;
            // a released output reads as the optional pull-up level
            r[i] = miso_oe ? miso : 1'b1;
            oe_seen = oe_seen | miso_oe;
            #24 bit_clk = 1'b0;
        end
    endtask
    // start: data falls while clock high
    task automatic i2c_start();
        sda_low = 1'b1;
        #48 bit_clk = 1'b0;
        #24;
    endtask
    // stop: data rises while clock high
    task automatic i2c_stop();
        sda_low = 1'b1;
        #24 bit_clk = 1'b1;
        #48 sda_low = 1'b0;
        #48;
    endtask
    // one bit: low phase 48 ns, high phase 48 ns
    task automatic i2c_bit(input logic o, output logic i);
        sda_low = !o;
        #24 bit_clk = 1'b1;
        #24 i = sda;
        #24 bit_clk = 1'b0;
        #24;
    endtask
    // eight bits then the ack slot; ack_in 1 releases the wire
    task automatic i2c_byte(input logic [7:0] b, input logic ack_in,
                            output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(b[i], r[i]);
        end
        i2c_bit(ack_in, ack);
    endtask
endmodule

// ### tb_top.sv
// bench of the dual-mode control port: i2c first, then reset into spi.
// assumes dmcp_host.sv and the design files are compiled before it.
`timescale 1ns/1ps
module tb_top;
    logic ref_clk; // system clock
    logic rst_b; // chip reset
    wire logic bclk, sel_n, mosi, sda_low, so, so_oe, sda_o, sda_oe;
    wire logic sda; // pulled-up data wire
    logic [64*8-1:0] regs; // register contents
    logic spi_mode;
    logic [6:0] saddr;
    logic strap1; // address strap bit1, caught at reset
    int bad_count;
    int total_checks;
    assign sda = !(sda_oe && !sda_o) && !sda_low;
    dmcp_ctrl_port i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .control_bit_clock(bclk),
        .select_or_addr0_pin(sel_n), .addr_strap_bit1(strap1), .control_serial_in(mosi),
        .control_serial_out(so), .control_serial_out_oe(so_oe), .i2c_data_in(sda),
        .i2c_data_out(sda_o), .i2c_data_oe(sda_oe), .cfg_regs(regs),
        .ctrl_mode_spi(spi_mode), .i2c_slave_addr(saddr));
    dmcp_host i_host (.bit_clk(bclk), .sel_n(sel_n), .mosi(mosi), .sda_low(sda_low),
        .miso(so), .miso_oe(so_oe), .sda(sda));
    // free-running system clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // one compare for every byte-sized result
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] reg_at(input int k);
        return regs[8*k +: 8];
    endfunction
    // link edges afterwards fall between system clock edges
    task automatic gap();
        repeat (10) @(posedge ref_clk);
        #3;
    endtask
    // reset pulse of 12 cycles, inputs moved on the rising edge
    task automatic do_reset();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        gap();
    endtask
    // straps caught and everything cleared
    task automatic t_reset(input logic [7:0] exp_addr);
        check("regs nonzero", 8'h00, {7'h0, |regs});
        check("mode", 8'h00, {7'h0, spi_mode});
        check("slave addr", exp_addr, {1'b0, saddr});
        check("sda out", 8'h00, {7'h0, sda_o});
    endtask
    // wrong address refused, then pointer with increment and two data bytes
    task automatic t_i2c_write();
        logic [7:0] r;
        logic a;
        i_host.i2c_start();
        i_host.i2c_byte(8'h9c, 1'b1, r, a);
        check("ack wrong addr", 8'h01, {7'h0, a});
        i_host.i2c_stop();
        i_host.i2c_start();
        i_host.i2c_byte(8'h9a, 1'b1, r, a);
        check("ack addr", 8'h00, {7'h0, a});
        i_host.i2c_byte(8'h83, 1'b1, r, a);
        check("ack ptr", 8'h00, {7'h0, a});
        i_host.i2c_byte(8'ha5, 1'b1, r, a);
        i_host.i2c_byte(8'h3c, 1'b1, r, a);
        check("ack data", 8'h00, {7'h0, a});
        i_host.i2c_stop();
        gap();
        check("reg3", 8'ha5, reg_at(3));
        check("reg4", 8'h3c, reg_at(4));
    endtask
    // pointer-only write, stop, then read twice with increment off
    task automatic t_i2c_read();
        logic [7:0] r;
        logic a;
        i_host.i2c_start();
        i_host.i2c_byte(8'h9a, 1'b1, r, a);
        i_host.i2c_byte(8'h03, 1'b1, r, a);
        i_host.i2c_stop();
        i_host.i2c_start();
        i_host.i2c_byte(8'h9b, 1'b1, r, a);
        check("ack read addr", 8'h00, {7'h0, a});
        i_host.i2c_byte(8'hff, 1'b0, r, a);
        check("read 1", 8'ha5, r);
        i_host.i2c_byte(8'hff, 1'b1, r, a);
        check("read 2", 8'ha5, r);
        i_host.i2c_stop();
    endtask
    // one spi frame of up to four bytes; last two results in rx
    task automatic frame(input int n, input logic [31:0] tx, output logic [15:0] rx);
        logic [7:0] r;
        i_host.spi_sel(1'b1);
        for (int i = 0; i < n; i++) begin
            i_host.spi_byte(tx[31-8*i -: 8], r);
            rx = {rx[7:0], r};
        end
        i_host.spi_sel(1'b0);
        gap();
    endtask
    // mode pick, incrementing write, wrong chip address
    task automatic t_spi_write();
        logic [15:0] rx;
        check("mode early", 8'h00, {7'h0, spi_mode});
        frame(4, 32'h9e851122, rx);
        check("mode", 8'h01, {7'h0, spi_mode});
        check("reg5", 8'h11, reg_at(5));
        check("reg6", 8'h22, reg_at(6));
        check("oe in write", 8'h00, {7'h0, i_host.oe_seen});
        frame(3, 32'h9c07ff00, rx);
        check("reg7", 8'h00, reg_at(7));
    endtask
    // reads with increment off, then on
    task automatic t_spi_read();
        logic [15:0] rx;
        frame(2, 32'h9e050000, rx);
        frame(3, 32'h9f000000, rx);
        check("hold rd", 8'h11, rx[15:8]);
        check("hold rd2", 8'h11, rx[7:0]);
        check("oe in read", 8'h01, {7'h0, i_host.oe_seen});
        frame(2, 32'h9e850000, rx);
        frame(3, 32'h9fffff00, rx);
        check("inc rd", 8'h11, rx[15:8]);
        check("inc rd2", 8'h22, rx[7:0]);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst_b = 1'b0;
        strap1 = 1'b0;
        bad_count = 0;
        total_checks = 0;
        do_reset();
        t_reset(8'h4d);
        t_i2c_write();
        t_i2c_read();
        i_host.spi_idle();
        strap1 <= 1'b1;
        do_reset();
        t_reset(8'h4f);
        t_spi_write();
        t_spi_read();
        print_verdict();
    end
    // watchdog well past the expected run
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end
endmodule
